// ---- fpd_map.vh ----
// Constants for the three-channel fan drive block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 25 MHz clock and an 8-bit register port.
`ifndef FPD_MAP_VH
`define FPD_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FPD_DUTY_NOW_1 8'h30
`define FPD_DUTY_NOW_2 8'h31
`define FPD_DUTY_NOW_3 8'h32
`define FPD_DRIVE_SETUP_1 8'h5c
`define FPD_DRIVE_SETUP_2 8'h5d
`define FPD_DRIVE_SETUP_3 8'h5e
`define FPD_RATE_SETUP_1 8'h5f
`define FPD_RATE_SETUP_2 8'h60
`define FPD_RATE_SETUP_3 8'h61

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FPD_SPIN_HI 2
`define FPD_SPIN_LO 0
`define FPD_POL_BIT 4
`define FPD_BHV_HI 7
`define FPD_BHV_LO 5
`define FPD_LRATE_HI 2
`define FPD_LRATE_LO 0
`define FPD_HIRATE_BIT 3

// ----------------------------------------------------------------
// Behaviour codes
// ----------------------------------------------------------------
`define FPD_BHV_REMOTE1 3'h0
`define FPD_BHV_LOCAL 3'h1
`define FPD_BHV_REMOTE2 3'h2
`define FPD_BHV_FULL 3'h3
`define FPD_BHV_OFF 3'h4
`define FPD_BHV_FAST_LR2 3'h5
`define FPD_BHV_FAST_ALL 3'h6
`define FPD_BHV_MANUAL 3'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FPD_DUTY_RST 8'hff
`define FPD_DRIVE_RST 8'h82
`define FPD_RATE_RST 8'h04

// ----------------------------------------------------------------
// Timing: clock rate and derived counts
// ----------------------------------------------------------------
`define FPD_CLK_HZ 25000000
`define FPD_HI_RATE_HZ 22500
// Cycles per duty step: period / 256, rounded down
`define FPD_HI_STEP (`FPD_CLK_HZ / (`FPD_HI_RATE_HZ * 256))
// Low rates in tenths of a hertz
`define FPD_LR0_DHZ 110
`define FPD_LR1_DHZ 147
`define FPD_LR2_DHZ 221
`define FPD_LR3_DHZ 294
`define FPD_LR4_DHZ 353
`define FPD_LR5_DHZ 441
`define FPD_LR6_DHZ 588
`define FPD_LR7_DHZ 882
`define FPD_LSTEP(d) ((`FPD_CLK_HZ * 10) / ((d) * 256))
// Startup timeouts in milliseconds
`define FPD_TO1_MS 100
`define FPD_TO2_MS 250
`define FPD_TO3_MS 400
`define FPD_TO4_MS 667
`define FPD_TO5_MS 1000
`define FPD_TO6_MS 2000
`define FPD_TO7_MS 4000
`define FPD_MS_CYC (`FPD_CLK_HZ / 1000)
`define FPD_PULSES_NEEDED 2

`endif

// ---- fpd_pwm_gen.v ----
// One duty-cycle generator: step prescaler, 8-bit period counter, compare.
// Assumes the step count is held steady by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "fpd_map.vh"

module fpd_pwm_gen (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire [19:0] step_cycles,
  input wire [7:0] duty,
  input wire polarity_sel,
  input wire force_off,
  // Output
  output reg pwm_out
);

  reg [19:0] pre;
  reg [7:0] phase;
  wire active;

  // Full scale gives full duty, so 0xff compares as always on
  assign active = !force_off && ((duty == 8'hff) || (phase < duty));

  always @(posedge clk) begin
    if (!rst_n) begin
      pre <= 20'h0;
      phase <= 8'h0;
      pwm_out <= 1'b0;
    end else begin
      if (pre + 20'h1 >= step_cycles) begin
        pre <= 20'h0;
        phase <= phase + 8'h1;
      end else begin
        pre <= pre + 20'h1;
      end
      pwm_out <= active ^ polarity_sel;
    end
  end

endmodule // fpd_pwm_gen
`default_nettype wire

// ---- fpd_spin_ctl.v ----
// Spin-up sequencer for one channel: full drive until two fan pulses
// or a fixed time, with a startup timeout that flags a fault.
// Assumes fan_pulse is already synchronised and edge detected.
`timescale 1ns/1ps
`default_nettype none
`include "fpd_map.vh"

module fpd_spin_ctl (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire start,
  input wire [2:0] timeout_sel,
  input wire pulse_startup_disable,
  input wire fan_pulse,
  input wire [31:0] ms_cycles,
  // Status
  output reg spinning,
  output reg mask_low_speed,
  output reg fault
);

  localparam ST_IDLE = 3'b001;
  localparam ST_SPIN = 3'b010;
  localparam ST_HOLD = 3'b100;

  reg [2:0] state;
  reg [31:0] ms_div;
  reg [12:0] ms_left;
  reg [1:0] pulses;
  reg [12:0] to_ms;
  reg [31:0] to_ms_full;

  always @* begin
    case (timeout_sel)
      3'h1: to_ms_full = `FPD_TO1_MS;
      3'h2: to_ms_full = `FPD_TO2_MS;
      3'h3: to_ms_full = `FPD_TO3_MS;
      3'h4: to_ms_full = `FPD_TO4_MS;
      3'h5: to_ms_full = `FPD_TO5_MS;
      3'h6: to_ms_full = `FPD_TO6_MS;
      3'h7: to_ms_full = `FPD_TO7_MS;
      default: to_ms_full = 32'h0;
    endcase
    // Longest timeout is 4000 ms, which fits in 13 bits
    to_ms = to_ms_full[12:0];
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      ms_div <= 32'h0;
      ms_left <= 13'h0;
      pulses <= 2'h0;
      spinning <= 1'b0;
      mask_low_speed <= 1'b0;
      fault <= 1'b0;
    end else begin
      fault <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_SPIN;
            spinning <= 1'b1;
            mask_low_speed <= (to_ms != 13'h0);
            ms_left <= to_ms;
            ms_div <= 32'h0;
            pulses <= 2'h0;
          end
        end
        ST_SPIN: begin
          if (ms_div + 32'h1 >= ms_cycles) begin
            ms_div <= 32'h0;
            if (ms_left != 13'h0) ms_left <= ms_left - 13'h1;
          end else begin
            ms_div <= ms_div + 32'h1;
          end
          if (fan_pulse && pulses != 2'h3) pulses <= pulses + 2'h1;
          if (pulse_startup_disable) begin
            // Fixed-time spin-up ignores pulses entirely
            if (ms_left == 13'h0) begin
              state <= ST_HOLD;
              spinning <= 1'b0;
              mask_low_speed <= 1'b0;
            end
          end else if (fan_pulse && pulses + 2'h1 >= `FPD_PULSES_NEEDED) begin
            state <= ST_HOLD;
            spinning <= 1'b0;
            mask_low_speed <= 1'b0;
          end else if (ms_left == 13'h0 && to_ms != 13'h0) begin
            state <= ST_HOLD;
            spinning <= 1'b0;
            mask_low_speed <= 1'b0;
            fault <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (!start) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // fpd_spin_ctl
`default_nettype wire

// ---- fpd_fan_drive.v ----
// Top of the three-channel fan drive block. Registers are reached over a
// simple 8-bit address/write/read port; temperatures and thresholds come
// from neighbouring calibration logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "fpd_map.vh"

module fpd_fan_drive #(
  parameter NCH = 3,
  parameter [31:0] MS_CYCLES = `FPD_MS_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Global configuration
  input wire pulse_startup_disable,
  input wire overtemp_pin,
  // Temperatures: remote one, local, remote two, 8 bits each
  input wire [23:0] temp,
  input wire [23:0] fan_on_temp,
  input wire [23:0] ramp_span,
  input wire [23:0] off_hysteresis,
  input wire [23:0] lowest_duty,
  // Fans
  input wire [NCH-1:0] fan_pulse_input,
  output reg [NCH-1:0] pwm_drive,
  output reg [NCH-1:0] low_speed_mask,
  output reg [NCH-1:0] fan_fault,
  output reg [NCH-1:0] continuous_measure
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] duty_now [0:NCH-1];
  reg [7:0] drive_setup [0:NCH-1];
  reg [7:0] rate_setup [0:NCH-1];
  reg [NCH-1:0] pulse_s1;
  reg [NCH-1:0] pulse_s2;
  reg [NCH-1:0] pulse_s3;
  reg overtemp_pin_s1;
  reg overtemp_pin_s2;
  reg [2:0] fan_running;

  wire [NCH-1:0] pwm_raw;
  wire [NCH-1:0] spin;
  wire [NCH-1:0] spin_mask;
  wire [NCH-1:0] spin_fault;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      pulse_s1 <= {NCH{1'b0}};
      pulse_s2 <= {NCH{1'b0}};
      pulse_s3 <= {NCH{1'b0}};
      overtemp_pin_s1 <= 1'b0;
      overtemp_pin_s2 <= 1'b0;
    end else begin
      pulse_s1 <= fan_pulse_input;
      pulse_s2 <= pulse_s1;
      pulse_s3 <= pulse_s2;
      overtemp_pin_s1 <= overtemp_pin;
      overtemp_pin_s2 <= overtemp_pin_s1;
    end
  end

  // ----------------------------------------------------------------
  // Per-temperature automatic duty and on/off hysteresis
  // ----------------------------------------------------------------
  function [7:0] ramp_duty;
    input [7:0] t;
    input [7:0] ton;
    input [7:0] span;
    input [7:0] dmin;
    reg [8:0] over;
    reg [16:0] prod;
    reg [15:0] quo;
    begin
      over = {1'b0, t} - {1'b0, ton};
      prod = 17'h0;
      quo = 16'h0;
      if (t <= ton) begin
        ramp_duty = dmin;
      end else if (span == 8'h0 || over[7:0] >= span) begin
        ramp_duty = 8'hff;
      end else begin
        // Linear from lowest duty to full across the span
        prod = {9'h0, over[7:0]} * {9'h0, 8'hff - dmin};
        // Quotient stays below 255 - dmin, so its low byte is the whole of it
        quo = prod[15:0] / {8'h0, span};
        ramp_duty = dmin + quo[7:0];
      end
    end
  endfunction

  wire [7:0] auto_duty [0:2];
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_temp
      assign auto_duty[g] = fan_running[g] ?
        ramp_duty(temp[8*g+7:8*g], fan_on_temp[8*g+7:8*g], ramp_span[8*g+7:8*g],
                  lowest_duty[8*g+7:8*g]) : 8'h00;
      always @(posedge clk) begin
        if (!rst_n) begin
          fan_running[g] <= 1'b0;
        end else if (temp[8*g+7:8*g] > fan_on_temp[8*g+7:8*g]) begin
          fan_running[g] <= 1'b1;
        end else if ({1'b0, temp[8*g+7:8*g]} + {1'b0, off_hysteresis[8*g+7:8*g]} <
                     {1'b0, fan_on_temp[8*g+7:8*g]}) begin
          fan_running[g] <= 1'b0;
        end
      end
    end
  endgenerate

  function [7:0] max2;
    input [7:0] a;
    input [7:0] b;
    begin
      max2 = (a > b) ? a : b;
    end
  endfunction

  // ----------------------------------------------------------------
  // Per-channel datapath
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire [2:0] bhv = drive_setup[g][`FPD_BHV_HI:`FPD_BHV_LO];
      wire hi_rate = rate_setup[g][`FPD_HIRATE_BIT];
      wire is_off = (bhv == `FPD_BHV_OFF);
      reg [7:0] target;
      reg [19:0] step;
      reg [31:0] step_full;

      // Behaviour selects the duty source
      always @* begin
        case (bhv)
          `FPD_BHV_REMOTE1: target = auto_duty[0];
          `FPD_BHV_LOCAL: target = auto_duty[1];
          `FPD_BHV_REMOTE2: target = auto_duty[2];
          `FPD_BHV_FULL: target = 8'hff;
          `FPD_BHV_FAST_LR2: target = max2(auto_duty[1], auto_duty[2]);
          `FPD_BHV_FAST_ALL: target = max2(auto_duty[0], max2(auto_duty[1], auto_duty[2]));
          `FPD_BHV_MANUAL: target = overtemp_pin_s2 ? 8'hff : duty_now[g];
          default: target = 8'h00;
        endcase
        if (spin[g]) target = 8'hff;
      end

      // Rate select to cycles per duty step
      always @* begin
        case (rate_setup[g][`FPD_LRATE_HI:`FPD_LRATE_LO])
          3'h0: step_full = `FPD_LSTEP(`FPD_LR0_DHZ);
          3'h1: step_full = `FPD_LSTEP(`FPD_LR1_DHZ);
          3'h2: step_full = `FPD_LSTEP(`FPD_LR2_DHZ);
          3'h3: step_full = `FPD_LSTEP(`FPD_LR3_DHZ);
          3'h4: step_full = `FPD_LSTEP(`FPD_LR4_DHZ);
          3'h5: step_full = `FPD_LSTEP(`FPD_LR5_DHZ);
          3'h6: step_full = `FPD_LSTEP(`FPD_LR6_DHZ);
          default: step_full = `FPD_LSTEP(`FPD_LR7_DHZ);
        endcase
        if (hi_rate) step_full = `FPD_HI_STEP;
        // Slowest rate needs 14 bits, so the low 20 bits hold every count
        step = step_full[19:0];
      end

      fpd_spin_ctl u_spin (
        .clk(clk),
        .rst_n(rst_n),
        .start(!is_off),
        .timeout_sel(drive_setup[g][`FPD_SPIN_HI:`FPD_SPIN_LO]),
        .pulse_startup_disable(pulse_startup_disable),
        .fan_pulse(pulse_s2[g] & ~pulse_s3[g]),
        .ms_cycles(MS_CYCLES),
        .spinning(spin[g]),
        .mask_low_speed(spin_mask[g]),
        .fault(spin_fault[g])
      );

      fpd_pwm_gen u_pwm (
        .clk(clk),
        .rst_n(rst_n),
        .step_cycles(step),
        .duty(target),
        .polarity_sel(drive_setup[g][`FPD_POL_BIT]),
        .force_off(is_off),
        .pwm_out(pwm_raw[g])
      );

      // Duty register follows the driven duty outside manual mode
      always @(posedge clk) begin
        if (!rst_n) begin
          duty_now[g] <= `FPD_DUTY_RST;
          drive_setup[g] <= `FPD_DRIVE_RST;
          rate_setup[g] <= `FPD_RATE_RST;
        end else begin
          if (reg_wr && reg_addr == `FPD_DRIVE_SETUP_1 + g) drive_setup[g] <= reg_wdata;
          if (reg_wr && reg_addr == `FPD_RATE_SETUP_1 + g) rate_setup[g] <= reg_wdata;
          if (bhv == `FPD_BHV_MANUAL && !spin[g] && !overtemp_pin_s2) begin
            if (reg_wr && reg_addr == `FPD_DUTY_NOW_1 + g)
              duty_now[g] <= reg_wdata;
          end else begin
            duty_now[g] <= target;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs and read mux
  // ----------------------------------------------------------------
  integer i;
  always @(posedge clk) begin
    if (!rst_n) begin
      pwm_drive <= {NCH{1'b0}};
      low_speed_mask <= {NCH{1'b0}};
      fan_fault <= {NCH{1'b0}};
      continuous_measure <= {NCH{1'b0}};
      reg_rdata <= 8'h00;
    end else begin
      pwm_drive <= pwm_raw;
      low_speed_mask <= spin_mask;
      fan_fault <= spin_fault;
      reg_rdata <= 8'h00;
      for (i = 0; i < NCH; i = i + 1) begin
        continuous_measure[i] <= rate_setup[i][`FPD_HIRATE_BIT];
        if (reg_addr == `FPD_DUTY_NOW_1 + i) reg_rdata <= duty_now[i];
        if (reg_addr == `FPD_DRIVE_SETUP_1 + i) reg_rdata <= drive_setup[i];
        if (reg_addr == `FPD_RATE_SETUP_1 + i) reg_rdata <= rate_setup[i];
      end
    end
  end

endmodule // fpd_fan_drive
`default_nettype wire

// ---- fpd_drive_props.sv ----
// Checker for the fan drive top; sees only its ports.
// Assumes one clock domain; channel one setup is shadowed from observed writes.
`timescale 1ns/1ps
`default_nettype none
`include "fpd_map.vh"

module fpd_drive_props #(
  parameter NCH = 3,
  parameter [31:0] MS_CYCLES = 32'd25000
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire overtemp_pin,
  // Fans
  input wire [NCH-1:0] pwm_drive,
  input wire [NCH-1:0] low_speed_mask,
  input wire [NCH-1:0] fan_fault,
  input wire [NCH-1:0] continuous_measure
);
  // ----
  // Shadow of channel one setup
  // ----
  reg [7:0] drv1;
  reg [7:0] rate1;
  reg [3:0] age;
  wire hit = reg_wr && (reg_addr == `FPD_DRIVE_SETUP_1 || reg_addr == `FPD_RATE_SETUP_1);

  // Age gives the pipeline a few cycles to settle after a setup write
  always @(posedge clk) begin
    if (!rst_n) begin
      drv1 <= `FPD_DRIVE_RST;
      rate1 <= `FPD_RATE_RST;
      age <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == `FPD_DRIVE_SETUP_1) drv1 <= reg_wdata;
      if (reg_wr && reg_addr == `FPD_RATE_SETUP_1) rate1 <= reg_wdata;
      age <= hit ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----
  // Properties
  // ----
  measure_follow_a: assert property (
    age > 4'h2 |-> continuous_measure[0] == rate1[`FPD_HIRATE_BIT])
    else $error("measure flag differs from rate setup");
  off_level_a: assert property (
    age > 4'h2 && drv1[7:5] == `FPD_BHV_OFF |-> pwm_drive[0] == drv1[`FPD_POL_BIT])
    else $error("disabled channel not at zero duty level");
  spin_full_a: assert property (
    $rose(low_speed_mask[0]) |-> ##1 (pwm_drive[0] != drv1[`FPD_POL_BIT]) [*8])
    else $error("spin-up not at full duty");
  mask_timeout_a: assert property (
    age > 4'h2 && low_speed_mask[0] |-> drv1[2:0] != 3'h0)
    else $error("mask raised without a startup timeout");
  fault_window_a: assert property (
    |fan_fault |-> (fan_fault & ~$past(low_speed_mask)) == {NCH{1'b0}})
    else $error("fault outside startup window");
  fault_pulse_a: assert property (
    |fan_fault |=> (fan_fault & $past(fan_fault)) == {NCH{1'b0}})
    else $error("fault longer than one cycle");
  rate_back_a: assert property (
    reg_wr && reg_addr == `FPD_RATE_SETUP_1 ##1 reg_addr == `FPD_RATE_SETUP_1
    |=> reg_rdata == rate1)
    else $error("rate setup readback wrong");
  overtemp_full_a: assert property (
    overtemp_pin [*6] ##0 (reg_addr == `FPD_DUTY_NOW_1 && drv1[7:5] == `FPD_BHV_MANUAL)
    |=> reg_rdata == 8'hff)
    else $error("overtemperature did not force full duty");
endmodule // fpd_drive_props
`default_nettype wire

// ---- fpd_fan_model.sv ----
// Three fans with fan_pulse_input outputs for the fan drive bench.
// Assumes non-inverted drive; a dead fan's fan_pulse_input line sits at its pull-up.
`timescale 1ns/1ps
`default_nettype none

module fpd_fan_model (
  // Clock
  input wire logic clk,
  // Drive and fan kind
  input wire logic [2:0] pwm,
  input wire logic [2:0] alive,
  input wire logic [2:0] slow,
  // Fan_pulse_input
  output logic [2:0] pulse
);
  logic [7:0] spin [3] = '{8'h00, 8'h00, 8'h00};

  // Rotation advances only while driven; a slow fan needs eight times the drive
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (pwm[i]) spin[i] <= spin[i] + 8'h01;
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pulse[i] = !alive[i] || (slow[i] ? spin[i][7] : spin[i][4]);
    end
  end
endmodule // fpd_fan_model
`default_nettype wire

// ---- fpd_fan_drive_tb.sv ----
// Self-checking bench for the fan drive top: register tasks and scenarios.
// Assumes the fan model and the checker bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "fpd_map.vh"

module fpd_fan_drive_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = `FPD_DUTY_NOW_1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic psd = 1'b0;
  logic overtemp_pin = 1'b0;
  logic [23:0] temp = 24'h0;
  logic [23:0] ton = 24'h282828;
  logic [23:0] span = 24'h141414;
  logic [23:0] hyst = 24'h050505;
  logic [23:0] pmin = 24'h404040;
  logic [2:0] pulse_in, pwm_drive, lsm, fault, cmeas;
  logic [7:0] setups [3] = '{8'he0, 8'he0, 8'hf0};
  logic [7:0] duties [3] = '{8'h54, 8'h00, 8'h54};
  logic [15:0] highs [3] = '{16'd336, 16'd0, 16'd688};
  logic [15:0] p, m, f;
  logic [7:0] v;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  fpd_fan_drive #(.NCH(3), .MS_CYCLES(10)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pulse_startup_disable(psd),
    .overtemp_pin(overtemp_pin), .temp(temp), .fan_on_temp(ton), .ramp_span(span),
    .off_hysteresis(hyst), .lowest_duty(pmin), .fan_pulse_input(pulse_in),
    .pwm_drive(pwm_drive), .low_speed_mask(lsm), .fan_fault(fault),
    .continuous_measure(cmeas));
  fpd_fan_model fans (.clk(clk), .pwm(pwm_drive), .alive(3'b101), .slow(3'b100),
    .pulse(pulse_in));

  task automatic print_verdict;
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run needs about 10k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      print_verdict();
    end
  end

  // ----
  // Register and measuring tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic tally(input int ch, input int len, output logic [15:0] hp,
    output logic [15:0] hm, output logic [15:0] hf);
    hp = 16'h0;
    hm = 16'h0;
    hf = 16'h0;
    repeat (len) begin
      @(posedge clk);
      #1;
      hp = hp + pwm_drive[ch];
      hm = hm + lsm[ch];
      hf = hf + fault[ch];
    end
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk({8'h00, reg_rdata}, 16'h00ff);
    rc(`FPD_DRIVE_SETUP_1, 8'h82);
    rc(`FPD_RATE_SETUP_1, 8'h04);
    // Pulse spin-up on a prompt fan; duty writes refused meanwhile
    wr(`FPD_DRIVE_SETUP_1, 8'he1);
    wr(`FPD_DUTY_NOW_1, 8'h40);
    rc(`FPD_DUTY_NOW_1, 8'hff);
    tally(0, 1200, p, m, f);
    chk(f, 16'h0);
    wr(`FPD_DUTY_NOW_1, 8'h40);
    rc(`FPD_DUTY_NOW_1, 8'h40);
    // Dead fan: window of 100 ms then one fault
    wr(`FPD_DRIVE_SETUP_2, 8'he1);
    tally(1, 1200, p, m, f);
    chk(f, 16'h1);
    chk({15'h0, m > 16'd990 && m < 16'd1010}, 16'h1);
    // Fixed-time spin-up ignores the slow fan's early pulses
    @(posedge clk) psd <= 1'b1;
    wr(`FPD_DRIVE_SETUP_3, 8'he1);
    tally(2, 1200, p, m, f);
    chk({15'h0, m > 16'd990 && m < 16'd1010}, 16'h1);
    // High rate with low select nonzero: 1024-cycle period, 4 cycles a step
    wr(`FPD_RATE_SETUP_1, 8'h0f);
    rc(`FPD_RATE_SETUP_1, 8'h0f);
    chk({13'h0, cmeas}, 16'h1);
    for (int i = 0; i < 3; i++) begin
      wr(`FPD_DRIVE_SETUP_1, setups[i]);
      wr(`FPD_DUTY_NOW_1, duties[i]);
      repeat (1030) @(posedge clk);
      tally(0, 1024, p, m, f);
      chk(p, highs[i]);
    end
    // Overtemperature overrides and locks the manual duty
    @(posedge clk) overtemp_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rc(`FPD_DUTY_NOW_1, 8'hff);
    wr(`FPD_DUTY_NOW_1, 8'h10);
    rc(`FPD_DUTY_NOW_1, 8'hff);
    @(posedge clk) overtemp_pin <= 1'b0;
    // Automatic control on local temperature: on 40, span 20, hysteresis 5
    wr(`FPD_DRIVE_SETUP_2, 8'h20);
    @(posedge clk) temp <= 24'h006400;
    repeat (8) @(posedge clk);
    rc(`FPD_DUTY_NOW_2, 8'hff);
    @(posedge clk) temp <= 24'h001e00;
    repeat (8) @(posedge clk);
    rc(`FPD_DUTY_NOW_2, 8'h00);
    @(posedge clk) temp <= 24'h002600;
    repeat (8) @(posedge clk);
    rc(`FPD_DUTY_NOW_2, 8'h00);
    @(posedge clk) temp <= 24'h002900;
    repeat (8) @(posedge clk);
    @(posedge clk) temp <= 24'h002600;
    repeat (8) @(posedge clk);
    rd(`FPD_DUTY_NOW_2, v);
    chk({15'h0, v != 8'h00}, 16'h1);
    // Every behaviour code reads back; full speed shows full duty
    for (int c = 0; c < 8; c++) begin
      wr(`FPD_DRIVE_SETUP_3, {c[2:0], 5'h00});
      rc(`FPD_DRIVE_SETUP_3, {c[2:0], 5'h00});
      if (c == 3) rc(`FPD_DUTY_NOW_3, 8'hff);
    end
    print_verdict();
  end
endmodule // fpd_fan_drive_tb

bind fpd_fan_drive fpd_drive_props #(.NCH(NCH), .MS_CYCLES(MS_CYCLES)) props (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .overtemp_pin(overtemp_pin), .pwm_drive(pwm_drive),
  .low_speed_mask(low_speed_mask), .fan_fault(fan_fault),
  .continuous_measure(continuous_measure));
`default_nettype wire
